// *** tmr_pkg.sv ***
// constants, field layouts and carrier types of the 10-bit capture/compare timer
// assumes a single 250 MHz pclk domain and an APB master with 8-bit byte addresses

package tmr_pkg;

	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int          CNT_W    = 10;
	localparam logic [9:0]  CNT_RST  = 10'h000;
	localparam logic [9:0]  CMPA_RST = 10'h000;
	localparam logic [2:0]  CMPP_RST = 3'h0;
	localparam logic [7:0]  CTRL_RST = 8'h00;

	// ****************************************
	// register byte offsets
	// ****************************************
	localparam logic [7:0]  OFS_RUN    = 8'h00;
	localparam logic [7:0]  OFS_CTRL   = 8'h04;
	localparam logic [7:0]  OFS_CMPA   = 8'h08;
	localparam logic [7:0]  OFS_CMPP   = 8'h0C;
	localparam logic [7:0]  OFS_CNT_LO = 8'h10;
	localparam logic [7:0]  OFS_CNT_HI = 8'h14;
	localparam logic [7:0]  OFS_IRQ    = 8'h18;

	// match flag / enable bit positions in timer_match_irq_ctrl
	localparam int          IRQ_FA_BIT = 5;
	localparam int          IRQ_FP_BIT = 4;
	localparam int          IRQ_EA_BIT = 1;
	localparam int          IRQ_EP_BIT = 0;

	// ****************************************
	// mode and pin-action codes
	// ****************************************
	localparam logic [1:0]  MODE_CMP = 2'h0;
	localparam logic [1:0]  MODE_CAP = 2'h1;
	localparam logic [1:0]  MODE_PWM = 2'h2;
	localparam logic [1:0]  MODE_TMR = 2'h3;
	localparam logic [1:0]  PA_PULSE = 2'h3;
	localparam logic [1:0]  CAP_RISE = 2'h0;
	localparam logic [1:0]  CAP_FALL = 2'h1;
	localparam logic [1:0]  CAP_BOTH = 2'h2;
	localparam logic [1:0]  PA_LOW   = 2'h0;
	localparam logic [1:0]  PA_HIGH  = 2'h1;
	localparam logic [1:0]  PA_TOGL  = 2'h3;

	// ****************************************
	// carrier types
	// ****************************************
	// timer_ctrl_one layout, bit 7 down to bit 0
	typedef struct packed {
		logic [1:0] mode_sel;
		logic [1:0] pin_action;
		logic       output_init_level;
		logic       output_invert;
		logic       period_duty_swap;
		logic       clear_source_sel;
	} ctrl_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic rise;
		logic fall;
	} edge_type;

endpackage : tmr_pkg

// *** pin_edge.sv ***
// two-flop synchroniser and edge detector for one timer input pin
// assumes the pin may change at any time relative to pclk

`timescale 1ns/10ps

module pin_edge (
	input  wire logic              pclk,    // timer clock
	input  wire logic              presetn, // async reset, active low
	input  wire logic              pin,     // raw pin level
	output tmr_pkg::edge_type      edges    // one-cycle edge pulses
);
	import tmr_pkg::*;

	typedef struct packed {
		logic     meta;
		logic     sync;
		logic     prev;
		edge_type edges;
	} sync_type;

	sync_type s_q;
	sync_type s_d;

	// ****************************************
	// sampling and edge compare
	// ****************************************
	// meta is read only by sync
	always_comb begin
		s_d             = s_q;
		s_d.meta        = pin;
		s_d.sync        = s_q.meta;
		s_d.prev        = s_q.sync;
		s_d.edges.rise  = s_q.sync & ~s_q.prev;
		s_d.edges.fall  = ~s_q.sync & s_q.prev;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign edges = s_q.edges;

endmodule : pin_edge

// *** tmr_capture_compare.sv ***
// 10-bit timer with comparators a and p: compare, pwm, single pulse, capture
// assumes an APB master on pclk; pins are synchronised inside

`timescale 1ns/10ps

module tmr_capture_compare (
	input  wire logic              pclk,              // 250 MHz clock
	input  wire logic              presetn,           // async reset, active low
	input  tmr_pkg::apb_req_type   apb,               // apb request group
	output logic [31:0]            prdata,            // apb read data
	output logic                   pready,            // apb ready
	output logic                   pslverr,           // unmapped address
	input  wire logic              ext_trigger_pin,   // single pulse trigger
	input  wire logic              capture_input_pin, // capture source
	output logic                   timer_out,         // timer output pin
	output logic                   match_irq          // enabled flag request
);
	import tmr_pkg::*;

	typedef struct packed {
		logic [9:0]  cnt;
		logic [9:0]  cmpa;
		logic [2:0]  cmpp;
		ctrl_type    ctrl;
		logic        run;
		logic        run_prev;
		logic        fa;
		logic        fp;
		logic        ea;
		logic        ep;
		logic        out_lvl;
		logic        tout;
		logic        irq;
		logic [31:0] rdata;
		logic        ready;
		logic        err;
	} state_type;

	state_type   s_q;
	state_type   s_d;
	ctrl_type    nctrl;
	edge_type    trg_e;
	edge_type    cap_e;
	logic        setup;
	logic        wr;
	logic        pulse;
	logic [1:0]  mode;
	logic        run_rise;
	logic        running;
	logic [10:0] duty_lim;
	logic [9:0]  p_lim;
	logic        a_hit;
	logic        p_hit;
	logic        cap_hit;
	logic        duty;

	// single pulse decode, shared by logic and checks
	function automatic logic is_pulse(input ctrl_type c);
		return (c.mode_sel == MODE_PWM) && (c.pin_action == PA_PULSE);
	endfunction : is_pulse

	// ****************************************
	// pin synchronisers
	// ****************************************
	pin_edge u_trg (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (ext_trigger_pin),
		.edges   (trg_e)
	);

	pin_edge u_cap (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (capture_input_pin),
		.edges   (cap_e)
	);

	// ****************************************
	// decodes
	// ****************************************
	// apb phases and timer events
	assign setup    = apb.psel & ~apb.penable;
	assign wr       = apb.psel & apb.penable & s_q.ready & apb.pwrite;
	assign pulse    = is_pulse(s_q.ctrl);
	assign mode     = s_q.ctrl.mode_sel;
	assign run_rise = s_q.run & ~s_q.run_prev;
	assign running  = s_q.run & ~run_rise;
	assign duty_lim = {~|s_q.cmpp, s_q.cmpp, 7'h00};  // zero means 1024
	assign p_lim    = 10'(duty_lim - 11'h001);
	assign a_hit    = running && (s_q.cnt == s_q.cmpa);
	assign p_hit    = running && (s_q.cnt == p_lim);
	// selected capture edge, none for 11
	assign cap_hit  = (s_q.ctrl.pin_action == CAP_RISE) ? cap_e.rise :
	                  (s_q.ctrl.pin_action == CAP_FALL) ? cap_e.fall :
	                  (s_q.ctrl.pin_action == CAP_BOTH) ? (cap_e.rise | cap_e.fall) :
	                  1'b0;
	assign duty     = s_q.ctrl.period_duty_swap ? ({1'b0, s_q.cnt} < duty_lim) :
	                  (s_q.cnt < s_q.cmpa);

	// ****************************************
	// next state
	// ****************************************
	// bus writes first, so timer sets and captures win
	always_comb begin
		s_d          = s_q;
		nctrl        = ctrl_type'(apb.pwdata[7:0]);
		s_d.run_prev = s_q.run;
		s_d.ready    = setup;
		s_d.rdata    = 32'h0000_0000;
		s_d.err      = 1'b0;
		if (wr) begin
			case (apb.paddr)
				OFS_RUN:  s_d.run = apb.pwdata[0];
				OFS_CTRL: begin
					// locked pin action while in single pulse
					if (pulse && (nctrl.mode_sel == MODE_PWM)) begin
						nctrl.pin_action = PA_PULSE;
					end
					s_d.ctrl = nctrl;
				end
				OFS_CMPA: s_d.cmpa = apb.pwdata[9:0];
				OFS_CMPP: s_d.cmpp = apb.pwdata[2:0];
				OFS_IRQ:  begin
					s_d.fa = s_q.fa & apb.pwdata[IRQ_FA_BIT];
					s_d.fp = s_q.fp & apb.pwdata[IRQ_FP_BIT];
					s_d.ea = apb.pwdata[IRQ_EA_BIT];
					s_d.ep = apb.pwdata[IRQ_EP_BIT];
				end
				default: ;
			endcase
		end
		// counter engine
		if (run_rise) begin
			s_d.cnt     = CNT_RST;
			s_d.out_lvl = pulse | s_q.ctrl.output_init_level;
		end else if (!s_q.run && pulse) begin
			s_d.out_lvl = 1'b0;
		end else if (running) begin
			s_d.cnt = s_q.cnt + 10'h001;
			case (mode)
				MODE_CAP: begin
					if (p_hit) begin
						s_d.cnt = CNT_RST;
						s_d.fp  = 1'b1;
					end
					if (cap_hit) begin
						s_d.cmpa = s_q.cnt;
						s_d.fa   = 1'b1;
					end
				end
				MODE_PWM: begin
					if (pulse) begin
						// p, clear source and swap take no part here
						if (a_hit) begin
							s_d.cnt     = s_q.cnt;
							s_d.run     = 1'b0;
							s_d.out_lvl = 1'b0;
							s_d.fa      = 1'b1;
						end
					end else begin
						// period from swap bit only
						if (s_q.ctrl.period_duty_swap ? a_hit : p_hit) begin
							s_d.cnt = CNT_RST;
						end
						if (a_hit) begin
							s_d.fa = 1'b1;
						end
						if (p_hit) begin
							s_d.fp = 1'b1;
						end
						case (s_q.ctrl.pin_action)
							PA_LOW:  s_d.out_lvl = 1'b0;
							PA_HIGH: s_d.out_lvl = 1'b1;
							default: s_d.out_lvl = duty ? s_q.ctrl.output_init_level :
							                              ~s_q.ctrl.output_init_level;
						endcase
					end
				end
				default: begin
					// compare and plain timer modes
					if (s_q.ctrl.clear_source_sel ? a_hit : p_hit) begin
						s_d.cnt = CNT_RST;
					end
					if (p_hit && !s_q.ctrl.clear_source_sel) begin
						s_d.fp = 1'b1;
					end
					if (a_hit && (s_q.cmpa != CMPA_RST)) begin
						s_d.fa = 1'b1;
						case (s_q.ctrl.pin_action)
							2'h1:    s_d.out_lvl = 1'b0;
							2'h2:    s_d.out_lvl = 1'b1;
							PA_TOGL: s_d.out_lvl = ~s_q.out_lvl;
							default: ;
						endcase
					end
				end
			endcase
		end
		// trigger pin raises run in single pulse
		if (pulse && trg_e.rise && !s_q.run) begin
			s_d.run = 1'b1;
		end
		// no output in capture or plain timer mode
		if ((s_d.ctrl.mode_sel == MODE_CAP) || (s_d.ctrl.mode_sel == MODE_TMR)) begin
			s_d.tout = 1'b0;
		end else begin
			s_d.tout = s_d.out_lvl ^ s_d.ctrl.output_invert;
		end
		s_d.irq = (s_d.fa & s_d.ea) | (s_d.fp & s_d.ep);
		// read data sampled in the setup cycle
		if (setup) begin
			case (apb.paddr)
				OFS_RUN:    s_d.rdata = {31'h0000_0000, s_q.run};
				OFS_CTRL:   s_d.rdata = {24'h00_0000, s_q.ctrl};
				OFS_CMPA:   s_d.rdata = {22'h00_0000, s_q.cmpa};
				OFS_CMPP:   s_d.rdata = {29'h0000_0000, s_q.cmpp};
				OFS_CNT_LO: s_d.rdata = {24'h00_0000, s_q.cnt[7:0]};
				OFS_CNT_HI: s_d.rdata = {30'h0000_0000, s_q.cnt[9:8]};
				OFS_IRQ:    s_d.rdata = {26'h000_0000, s_q.fa, s_q.fp, 2'h0, s_q.ea, s_q.ep};
				default:    s_d.err   = 1'b1;
			endcase
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q      <= '0;
			s_q.ctrl <= ctrl_type'(CTRL_RST);
			s_q.cnt  <= CNT_RST;
			s_q.cmpa <= CMPA_RST;
			s_q.cmpp <= CMPP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata    = s_q.rdata;
	assign pready    = s_q.ready;
	assign pslverr   = s_q.err;
	assign timer_out = s_q.tout;
	assign match_irq = s_q.irq;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pulse_start: assert property (run_rise && pulse |=> s_q.out_lvl && (s_q.cnt == CNT_RST))
		else $error("pulse did not start with counter at zero");
	a_pulse_end: assert property (pulse && a_hit && !wr |=> !s_q.run && s_q.fa && !s_q.out_lvl)
		else $error("compare a match did not end the pulse");
	a_pulse_hold: assert property (pulse && !s_q.run |=> s_q.cnt == $past(s_q.cnt))
		else $error("stopped pulse counter moved");
	a_trig_run: assert property (pulse && trg_e.rise && !s_q.run && !wr |=> s_q.run ##1 s_q.out_lvl)
		else $error("trigger edge did not start a pulse");
	a_cap_copy: assert property ((mode == MODE_CAP) && running && cap_hit |=>
		(s_q.cmpa == $past(s_q.cnt)) && s_q.fa)
		else $error("capture edge did not copy counter");
	a_cap_wrap: assert property ((mode == MODE_CAP) && p_hit |=> (s_q.cnt == CNT_RST) && s_q.fp)
		else $error("compare p match did not wrap counter");
	a_cap_none: assert property ((mode == MODE_CAP) && (s_q.ctrl.pin_action == PA_PULSE) && !wr
		|=> $stable(s_q.cmpa))
		else $error("capture happened with capture disabled");
	a_cap_count: assert property ((mode == MODE_CAP) && running && !p_hit
		|=> s_q.cnt == 10'($past(s_q.cnt) + 10'h001))
		else $error("capture counter did not advance");
	a_cap_no_out: assert property ((mode == MODE_CAP) [*2] |-> !timer_out)
		else $error("output driven in capture mode");
	a_apb_ready: assert property (setup |=> pready ##1 !pready || setup)
		else $error("apb ready not given after setup");

	c_pulse_done: cover property (pulse && a_hit);
	c_capture:    cover property ((mode == MODE_CAP) && running && cap_hit);
	c_cap_wrap:   cover property ((mode == MODE_CAP) && p_hit);
	c_pwm_period: cover property ((mode == MODE_PWM) && !pulse && p_hit);

endmodule : tmr_capture_compare

// *** pin_source.sv ***
// trigger and capture pin sources for the timer bench
// assumes the bench calls drive from one process at a time
`timescale 1ns/10ps

module pin_source (
	input  wire logic pclk, // timer clock
	output logic      trig, // trigger pin level
	output logic      cap   // capture pin level
);
	// ****************************************
	// pin drivers
	// ****************************************
	initial begin
		trig = 1'b0;
		cap  = 1'b0;
	end

	// set one pin, then hold it past the synchroniser delay
	task automatic drive(input bit which, input logic lvl);
		@(posedge pclk);
		if (which) begin
			trig <= lvl;
		end else begin
			cap <= lvl;
		end
		repeat (8) @(posedge pclk);
	endtask : drive
endmodule : pin_source

// *** tmr_capture_compare_tb.sv ***
// self-checking bench for the capture/compare timer
// assumes zero wait state apb answers and a 250 MHz pclk
`timescale 1ns/10ps

module tmr_capture_compare_tb;
	import tmr_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        pclk;
	logic        presetn;
	apb_req_type apb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        trig;
	logic        cap;
	logic        timer_out;
	logic        match_irq;
	int          mismatches;
	int          n_compared;
	int          cycles;
	logic [31:0] v;
	logic [31:0] w;
	logic        e;

	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	tmr_capture_compare u_tmr_capture_compare (
		.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_trigger_pin(trig), .capture_input_pin(cap), .timer_out(timer_out), .match_irq(match_irq)
	);
	pin_source u_pin_source (.pclk(pclk), .trig(trig), .cap(cap));

	// ****************************************
	// bus and compare tasks
	// ****************************************
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge pclk);
		apb.penable <= 1'b1;
		@(posedge pclk);
		// wait for pready; the hang guard ends this only if pready never comes
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		v = prdata;
		e = pslverr;
		apb <= '0;
	endtask : xfer

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(v, exp);
	endtask : rd

	// run low then high, so the counter restarts
	task automatic restart();
		wr(OFS_RUN, 32'h0);
		wr(OFS_RUN, 32'h1);
	endtask : restart

	// count the cycles of one high pulse on the output
	task automatic pulse_width(input int exp);
		int wdt;
		int n;
		wdt = 0;
		n = 0;
		while (n < 100) begin
			@(negedge pclk);
			n++;
			if (timer_out === 1'b1) begin
				wdt++;
			end else if (wdt > 0) begin
				break;
			end
		end
		check(wdt, exp);
	endtask : pulse_width

	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		presetn = 1'b0;
		apb = '0;
		mismatches = 0;
		n_compared = 0;
		cycles = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_IRQ, 32'h0);
		rd(OFS_CNT_LO, 32'h0);
		xfer(1'b0, 8'h1C, 32'h0);
		check(e, 1);
		$display("test reset done");
		// single pulse started by software, width set by compare a
		wr(OFS_CMPA, 32'h5);
		wr(OFS_CTRL, 32'hB0);
		wr(OFS_RUN, 32'h1);
		pulse_width(6);
		rd(OFS_RUN, 32'h0);
		rd(OFS_IRQ, 32'h20);
		rd(OFS_CNT_LO, 32'h5);
		wr(OFS_CTRL, 32'h80);
		rd(OFS_CTRL, 32'hB0);
		wr(OFS_IRQ, 32'h22);
		repeat (2) @(posedge pclk);
		check(match_irq, 1);
		wr(OFS_IRQ, 32'h0);
		repeat (2) @(posedge pclk);
		check(match_irq, 0);
		// software clear ends the pulse before any match
		wr(OFS_CMPA, 32'h3FF);
		wr(OFS_RUN, 32'h1);
		repeat (4) @(negedge pclk);
		check(timer_out, 1);
		wr(OFS_RUN, 32'h0);
		repeat (2) @(negedge pclk);
		check(timer_out, 0);
		rd(OFS_IRQ, 32'h0);
		$display("test software pulse done");
		// pulse from the trigger pin with unused bits set
		wr(OFS_CMPA, 32'h3);
		wr(OFS_CMPP, 32'h1);
		wr(OFS_CTRL, 32'hB3);
		fork
			u_pin_source.drive(1'b1, 1'b1);
			pulse_width(4);
		join
		u_pin_source.drive(1'b1, 1'b0);
		rd(OFS_CNT_LO, 32'h3);
		$display("test trigger pulse done");
		// every capture edge code, both pin edges
		wr(OFS_CMPP, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(OFS_CTRL, {24'h0, 2'h1, c[1:0], 4'h0});
			restart();
			wr(OFS_IRQ, 32'h0);
			u_pin_source.drive(1'b0, 1'b1);
			rd(OFS_IRQ, (c == 0 || c == 2) ? 32'h20 : 32'h0);
			wr(OFS_IRQ, 32'h0);
			u_pin_source.drive(1'b0, 1'b0);
			rd(OFS_IRQ, (c == 1 || c == 2) ? 32'h20 : 32'h0);
		end
		xfer(1'b0, OFS_CMPA, 32'h0);
		w = v;
		check(w != 0, 1);
		// capture still off: a pin edge leaves compare a alone
		u_pin_source.drive(1'b0, 1'b1);
		rd(OFS_CMPA, w);
		u_pin_source.drive(1'b0, 1'b0);
		// rising capture lands six counts after the count read in setup
		wr(OFS_CTRL, 32'h40);
		xfer(1'b0, OFS_CNT_LO, 32'h0);
		w = v;
		u_pin_source.drive(1'b0, 1'b1);
		xfer(1'b0, OFS_CMPA, 32'h0);
		check(v & 32'hFF, (w + 32'h6) & 32'hFF);
		xfer(1'b0, OFS_CNT_LO, 32'h0);
		check(v !== w, 1);
		u_pin_source.drive(1'b0, 1'b0);
		$display("test capture done");
		// compare p bounds the count, output stays idle
		wr(OFS_CTRL, 32'h7F);
		wr(OFS_CMPP, 32'h1);
		restart();
		wr(OFS_IRQ, 32'h0);
		repeat (300) @(posedge pclk);
		check(timer_out, 0);
		rd(OFS_IRQ, 32'h10);
		rd(OFS_CNT_HI, 32'h0);
		xfer(1'b0, OFS_CNT_LO, 32'h0);
		check(v < 128, 1);
		wr(OFS_CMPP, 32'h0);
		restart();
		wr(OFS_IRQ, 32'h0);
		repeat (600) @(posedge pclk);
		rd(OFS_CNT_HI, 32'h2);
		rd(OFS_IRQ, 32'h0);
		$display("test capture period done");
		// pwm forced low still sets both match flags
		wr(OFS_CTRL, 32'h81);
		wr(OFS_CMPA, 32'hA);
		wr(OFS_CMPP, 32'h1);
		restart();
		wr(OFS_IRQ, 32'h0);
		repeat (300) @(posedge pclk);
		rd(OFS_IRQ, 32'h30);
		check(timer_out, 0);
		// pwm forced high, clear source still set
		wr(OFS_CTRL, 32'h91);
		wr(OFS_IRQ, 32'h0);
		repeat (300) @(posedge pclk);
		check(timer_out, 1);
		rd(OFS_IRQ, 32'h30);
		$display("test pwm done");
		finish_test();
	end
endmodule : tmr_capture_compare_tb
